// ### sadbc_top.sv
`timescale 1ns/1ns
module sadbc_top
  import sadbc_pkg::*;
(
  // clock and reset
  input  wire logic                       sys_clk,
  input  wire logic                       srst,
  // cpu bus
  input  wire logic [sadbc_pkg::ADDR_W-1:0] cpu_addr,
  input  wire logic                       cpu_cycle,
  input  wire logic                       cpu_write,
  // memory selects
  output logic                            flash_select_n,
  output logic                            sram_select,
  output logic                            vram_select,
  output logic                            vram_data_hit,
  // i/o selects
  output logic                            int_io_select,
  output logic                            ext_io_select,
  output logic                            card_reader_sel_1,
  output logic                            card_reader_sel_2,
  output logic                            card_reader_sel_3,
  // break compare
  output logic                            program_patch_service,
  output logic [sadbc_pkg::ADDR_W-1:0]   break_addr,
  // option peripheral selects, split off the shared option decode
  output logic                            option_periph_sel_1,
  output logic                            option_periph_sel_2
);
  import sadbc_pkg::*;

  // ==========================================================
  // elaboration checks
  // the comparators and state fields are sized for a 24-bit bus; a package
  // edit that breaks the window order would silently drop or double selects
  initial
  begin
    if (ADDR_W != 24)
      $error("sadbc_top: address bus must be 24 bits wide");
    if (VRAM_USED > (VRAM_HI - VRAM_LO + 24'h000001))
      $error("sadbc_top: used display area exceeds its window");
    if (SRAM_WRAP_LO > SRAM_LO)
      $error("sadbc_top: sram image must start below the primary region");
    if (PZ_FLASH_HI >= INT_IO_LO)
      $error("sadbc_top: page-zero flash image overlaps internal i/o");
    if (!((OPT_LO < OPT2_LO) && (OPT2_LO <= OPT_HI)))
      $error("sadbc_top: option split must fall inside the option window");
    if (BRK_WIN_LO < EXT_IO_LO)
      $error("sadbc_top: break window must lie in extended i/o");
    if ((CARD1_LO < INT_IO_LO) || ((CARD3_LO + CARD_SPAN) > INT_IO_HI))
      $error("sadbc_top: card reader slots must sit in internal i/o");
    if ((GA_REG_HI >= GA_EXP_LO) || (GA_EXP_HI >= CARD1_LO))
      $error("sadbc_top: gate-array bases overlap the card reader slots");
    if ((SRAM_HI < SRAM_LO) || (FLASH_HI >= SRAM_WRAP_LO))
      $error("sadbc_top: flash and sram windows overlap");
    if (VRAM_HI >= EXT_IO_LO)
      $error("sadbc_top: display window overlaps extended i/o");
  end

  // ==========================================================
  // state
  typedef struct packed {
    // break compare
    logic [23:0] brk;
    logic        nmi;
    // memory selects
    logic        flash_n;
    logic        sram;
    logic        vram;
    logic        vram_dat;
    // i/o selects
    logic        int_io;
    logic        ext_io;
    logic [2:0]  card;
    logic [1:0]  opt;
  } sadbc_state_s;

  sadbc_state_s st_reg;
  sadbc_state_s st_next;

  // ==========================================================
  // range decoders
  localparam int NSLOT = 10;
  logic [NSLOT-1:0] hit;
  logic [23:0]      lo_t [NSLOT];
  logic [23:0]      hi_t [NSLOT];

  // each window is one slot comparator; overlaps are settled in next state
  assign lo_t[0] = INT_IO_LO;
  assign hi_t[0] = INT_IO_HI;
  assign lo_t[1] = EXT_IO_LO;
  assign hi_t[1] = EXT_IO_HI;
  assign lo_t[2] = BRK_WIN_LO;
  assign hi_t[2] = BRK_WIN_HI;
  assign lo_t[3] = VRAM_LO;
  assign hi_t[3] = VRAM_HI;
  assign lo_t[4] = SRAM_WRAP_LO;
  assign hi_t[4] = SRAM_HI;
  assign lo_t[5] = FLASH_LO;
  assign hi_t[5] = FLASH_HI;
  assign lo_t[6] = GA_REG_LO;
  assign hi_t[6] = GA_REG_HI;
  assign lo_t[7] = GA_EXP_LO;
  assign hi_t[7] = GA_EXP_HI;
  assign lo_t[8] = OPT_LO;
  assign hi_t[8] = OPT_HI;
  assign lo_t[9] = FLASH_LO;
  assign hi_t[9] = PZ_FLASH_HI;

  genvar gi;
  generate
    for (gi = 0; gi < NSLOT; gi++)
    begin : g_slot
      sadbc_slot #(.W(24)) u_slot (
        .addr (cpu_addr),
        .lo   (lo_t[gi]),
        .hi   (hi_t[gi]),
        .hit  (hit[gi])
      );
    end
  endgenerate

  // card reader slots: only the lower two bytes of each slot respond
  logic [2:0]  card_hit;
  logic [23:0] card_base [3];
  assign card_base[0] = CARD1_LO;
  assign card_base[1] = CARD2_LO;
  assign card_base[2] = CARD3_LO;

  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_card
      sadbc_slot #(.W(24)) u_card (
        .addr (cpu_addr),
        .lo   (card_base[gi]),
        .hi   (card_base[gi] + CARD_SPAN),
        .hit  (card_hit[gi])
      );
    end
  endgenerate

  // gate-array internal bases never leave the block
  logic gate_array_reg_select;
  logic ga_exp_base;
  logic option_decode_select;
  assign gate_array_reg_select = hit[6] & ~(|card_hit);
  assign ga_exp_base           = hit[7] & ~(|card_hit);
  // shared option decode; both option selects are split off it below
  assign option_decode_select  = hit[8];

  // ==========================================================
  // next state
  // one cycle of latency buys registered, glitch-free selects and nmi
  always_comb
  begin
    st_next = st_reg;
    // stored break value; a write also compares, but the old value is used
    if (cpu_cycle && cpu_write && hit[2])
    begin
      st_next.brk = cpu_addr;
    end
    // full 24-bit compare on every bus cycle, no enable needed
    st_next.nmi = cpu_cycle && (cpu_addr == st_reg.brk);
    // page-zero flash image excludes the i/o area at its top
    st_next.flash_n  = ~(cpu_cycle && (hit[5] || hit[9]) && !hit[0]);
    st_next.sram     = cpu_cycle && hit[4];
    st_next.vram     = cpu_cycle && hit[3];
    st_next.vram_dat = cpu_cycle && hit[3]
                       && ((cpu_addr - VRAM_LO) < VRAM_USED);
    st_next.int_io   = cpu_cycle && hit[0];
    st_next.ext_io   = cpu_cycle && hit[1];
    st_next.card     = cpu_cycle ? card_hit : 3'h0;
    // option selects split off the shared option decode
    st_next.opt[0]   = cpu_cycle && option_decode_select && (cpu_addr < OPT2_LO);
    st_next.opt[1]   = cpu_cycle && option_decode_select && (cpu_addr >= OPT2_LO);
    // synchronous reset wins over any cycle; the flash enable parks inactive
    if (srst)
    begin
      st_next         = '0;
      st_next.brk     = BRK_RST;
      st_next.flash_n = 1'b1;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    st_reg <= st_next;
  end

  // ==========================================================
  // outputs
  // every select leaves a flip-flop, so no enable glitches while the bus settles
  assign flash_select_n        = st_reg.flash_n;
  assign sram_select           = st_reg.sram;
  assign vram_select           = st_reg.vram;
  assign vram_data_hit         = st_reg.vram_dat;
  assign int_io_select         = st_reg.int_io;
  assign ext_io_select         = st_reg.ext_io;
  assign card_reader_sel_1     = st_reg.card[0];
  assign card_reader_sel_2     = st_reg.card[1];
  assign card_reader_sel_3     = st_reg.card[2];
  assign program_patch_service = st_reg.nmi;
  assign break_addr            = st_reg.brk;
  assign option_periph_sel_1   = st_reg.opt[0];
  assign option_periph_sel_2   = st_reg.opt[1];

  // internal bases are decoded for register use inside the array only
  logic ga_base_unused;
  assign ga_base_unused = gate_array_reg_select ^ ga_exp_base;

endmodule : sadbc_top

// ### sadbc_pkg.sv
package sadbc_pkg;

  // address bus geometry
  localparam int unsigned ADDR_W = 24;

  // internal i/o region
  localparam logic [23:0] INT_IO_LO    = 24'h00ff80;
  localparam logic [23:0] INT_IO_HI    = 24'h00ffff;
  // extended i/o region
  localparam logic [23:0] EXT_IO_LO    = 24'hf00000;
  localparam logic [23:0] EXT_IO_HI    = 24'hffffff;
  // break address write window
  localparam logic [23:0] BRK_WIN_LO   = 24'hffff00;
  localparam logic [23:0] BRK_WIN_HI   = 24'hffffff;
  // display memory window and its used part
  localparam logic [23:0] VRAM_LO      = 24'hc00000;
  localparam logic [23:0] VRAM_HI      = 24'hc1ffff;
  localparam logic [23:0] VRAM_USED    = 24'h002580;
  // sram: primary region, and the wrapped 2mb base image
  localparam logic [23:0] SRAM_LO      = 24'h780000;
  localparam logic [23:0] SRAM_HI      = 24'h7fffff;
  localparam logic [23:0] SRAM_WRAP_LO = 24'h600000;
  // flash: 2mb array and page-zero image of its lowest 64kb
  localparam logic [23:0] FLASH_LO     = 24'h000000;
  localparam logic [23:0] FLASH_HI     = 24'h1fffff;
  localparam logic [23:0] PZ_FLASH_HI  = 24'h00ff7f;
  // page-zero i/o slots
  localparam logic [23:0] GA_REG_LO    = 24'h00ff80;
  localparam logic [23:0] GA_EXP_LO    = 24'h00ffa0;
  localparam logic [23:0] CARD1_LO     = 24'h00ffb0;
  localparam logic [23:0] CARD2_LO     = 24'h00ffb4;
  localparam logic [23:0] CARD3_LO     = 24'h00ffc0;
  localparam logic [23:0] OPT_LO       = 24'h00ffd0;
  localparam logic [23:0] OPT2_LO      = 24'h00ffd8;
  localparam logic [23:0] OPT_HI       = 24'h00ffdf;
  localparam logic [23:0] GA_REG_HI    = 24'h00ff9f;
  localparam logic [23:0] GA_EXP_HI    = 24'h00ffaf;
  localparam logic [23:0] CARD_SPAN    = 24'h000001;

  // value after reset
  localparam logic [23:0] BRK_RST      = 24'h000000;

endpackage : sadbc_pkg

// ### sadbc_slot.sv
`timescale 1ns/1ns
// range comparator: hit when lo <= addr <= hi
module sadbc_slot #(
  parameter int unsigned W = 24
) (
  // address and bounds
  input  wire logic [W-1:0] addr,
  input  wire logic [W-1:0] lo,
  input  wire logic [W-1:0] hi,
  // result
  output logic              hit
);
  initial
  begin
    if (W < 1) $error("sadbc_slot: width must be positive");
  end

  assign hit = (addr >= lo) && (addr <= hi);

endmodule : sadbc_slot

// ### sadbc_sva.sv
`timescale 1ns/1ns
module sadbc_sva
  import sadbc_pkg::*;
(
  // bus
  input wire logic        sys_clk,
  input wire logic        srst,
  input wire logic [23:0] cpu_addr,
  input wire logic        cpu_cycle,
  input wire logic        cpu_write,
  // watched outputs
  input wire logic        flash_select_n,
  input wire logic        sram_select,
  input wire logic        int_io_select,
  input wire logic        ext_io_select,
  input wire logic        program_patch_service,
  input wire logic [23:0] break_addr
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  // ==========
  // decode and break compare
  sequence s_set; cpu_cycle && cpu_write && cpu_addr >= BRK_WIN_LO; endsequence
  sequence s_hit; s_set ##1 cpu_cycle && cpu_addr == $past(cpu_addr); endsequence
  property p_int;
    cpu_cycle && cpu_addr inside {[INT_IO_LO:INT_IO_HI]} |=> int_io_select; endproperty
  a_int: assert property (p_int) else $error("int io");
  property p_ext; cpu_cycle && cpu_addr >= EXT_IO_LO |=> ext_io_select; endproperty
  a_ext: assert property (p_ext) else $error("ext io");
  property p_brk; s_set |=> break_addr == $past(cpu_addr); endproperty
  a_brk: assert property (p_brk) else $error("break store");
  property p_nmi;
    cpu_cycle && cpu_addr == break_addr |=> program_patch_service; endproperty
  a_nmi: assert property (p_nmi) else $error("nmi");
  // the cycle after a window write already compares against the new value
  property p_hit; s_hit |=> program_patch_service; endproperty
  a_hit: assert property (p_hit) else $error("set then hit");
  property p_sram; cpu_cycle && cpu_addr[23:21] == 3'h3 |=> sram_select; endproperty
  a_sram: assert property (p_sram) else $error("sram");
  property p_flash; cpu_cycle && cpu_addr < INT_IO_LO |=> !flash_select_n; endproperty
  a_flash: assert property (p_flash) else $error("flash");
  property p_idle;
    !cpu_cycle |=> flash_select_n && !sram_select && !program_patch_service; endproperty
  a_idle: assert property (p_idle) else $error("idle");
endmodule : sadbc_sva

// ### sadbc_cpu_model.sv
`timescale 1ns/1ns
module sadbc_cpu_model
  import sadbc_pkg::*;
(
  // bus toward the decoder
  output logic [23:0] cpu_addr,
  output logic        cpu_cycle,
  output logic        cpu_write
);
  initial {cpu_addr, cpu_cycle, cpu_write} = '0;
  // called just after a rising edge; an idle bus shows no stale address
  task automatic drive(input logic [23:0] a, input logic c, input logic w);
    cpu_addr <= c ? a : ~cpu_addr;
    cpu_cycle <= c;
    cpu_write <= c & w;
  endtask : drive
endmodule : sadbc_cpu_model

// ### test_sadbc_top.sv
`timescale 1ns/1ns
module test_sadbc_top;
  import sadbc_pkg::*;
  logic        sys_clk = 1'b0;
  logic        srst = 1'b1;
  logic        rst_req = 1'b0;
  wire  [23:0] cpu_addr, break_addr;
  wire         cpu_cycle, cpu_write;
  wire  [11:0] got;
  logic [23:0] brk = 24'h000000;
  logic [35:0] q[$];
  int          num_errors = 0;
  int          tests_run = 0;
  logic [23:0] dirs[] = '{24'h000000, 24'h00ff7f, 24'h00ff80, 24'h00ffff, 24'h1fffff,
    24'h200000, 24'h5fffff, 24'h600000, 24'h7fffff, 24'hc0257f, 24'hc02580, 24'hc1ffff,
    24'hc20000, 24'hf00000, 24'h00ffb1, 24'h00ffb2, 24'h00ffb4, 24'h00ffc1, 24'h00ffc2,
    24'h00ffd7, 24'h00ffd8, 24'h00ffdf, 24'h00ffe0};
  initial forever #25 sys_clk = ~sys_clk;
  sadbc_cpu_model sadbc_cpu_model_i (.cpu_addr(cpu_addr), .cpu_cycle(cpu_cycle),
    .cpu_write(cpu_write));
  sadbc_top sadbc_top_i (.sys_clk(sys_clk), .srst(srst), .cpu_addr(cpu_addr),
    .cpu_cycle(cpu_cycle), .cpu_write(cpu_write), .flash_select_n(got[11]),
    .sram_select(got[10]), .vram_select(got[9]), .vram_data_hit(got[8]),
    .int_io_select(got[7]), .ext_io_select(got[6]), .card_reader_sel_1(got[5]),
    .card_reader_sel_2(got[4]), .card_reader_sel_3(got[3]), .option_periph_sel_1(got[2]),
    .option_periph_sel_2(got[1]), .program_patch_service(got[0]), .break_addr(break_addr));
  // ==========
  // reference model: selects one cycle late, break value updated after compare
  function automatic logic [35:0] model(input logic [23:0] a, input logic c, input logic w,
    input logic rs);
    logic [11:0] s;
    logic io;
    io = a inside {[INT_IO_LO:INT_IO_HI]};
    s = {!(a <= FLASH_HI && !io), a inside {[SRAM_WRAP_LO:SRAM_HI]},
      a inside {[VRAM_LO:VRAM_HI]}, a >= VRAM_LO && a < VRAM_LO + 24'h002580, io,
      a >= EXT_IO_LO, a inside {[24'h00ffb0:24'h00ffb1]}, a inside {[24'h00ffb4:24'h00ffb5]},
      a inside {[24'h00ffc0:24'h00ffc1]}, a inside {[24'h00ffd0:24'h00ffd7]},
      a inside {[24'h00ffd8:24'h00ffdf]}, a == brk};
    if (!c || rs)
      s = 12'h800;
    if (rs)
      brk = BRK_RST;
    else if (c && w && a >= BRK_WIN_LO)
      brk = a;
    return {s, brk};
  endfunction : model
  task automatic stop_test;
    if (num_errors == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : stop_test
  // inputs go out on a rising edge; the answer stands from the next rising
  // edge and is looked at on the falling edge after it, clear of both edges
  task automatic step(input logic [23:0] a, input logic c, input logic w);
    logic [35:0] x;
    @(posedge sys_clk);
    srst <= rst_req;
    sadbc_cpu_model_i.drive(a, c, w);
    q.push_back(model(a, c, w, rst_req));
    @(negedge sys_clk);
    if (q.size() == 2)
    begin
      x = q.pop_front();
      tests_run++;
      if ({got, break_addr} !== x)
      begin
        num_errors++;
        $display("wrong value at %0t: got %h want %h", $time, {got, break_addr}, x);
      end
    end
  endtask : step
  initial
  begin
    logic [31:0] r;
    void'($urandom(32'hc89c91f8));
    repeat (4) @(posedge sys_clk);
    srst <= 1'b0;
    foreach (dirs[i]) step(dirs[i], 1'b1, 1'b0);
    step(24'hffff10, 1'b1, 1'b1);
    step(24'hffff10, 1'b1, 1'b0);
    step(24'hffff10, 1'b0, 1'b1);
    step(24'h123456, 1'b1, 1'b1);
    repeat (2)
    begin
      repeat (200)
      begin
        r = $urandom;
        step(r[25] ? r[23:0] : (r[24] ? brk : {16'hffff, r[7:0]}), r[26] | r[27], r[28]);
      end
      // mid-run reset: a window write under reset is dropped, and the cleared
      // break value matches address zero at the first cycle after release
      rst_req = 1'b1;
      step(24'hffff20, 1'b1, 1'b1);
      step(24'hffff20, 1'b1, 1'b0);
      rst_req = 1'b0;
      step(BRK_RST, 1'b1, 1'b0);
    end
    step(24'h000000, 1'b0, 1'b0);
    step(24'h000000, 1'b0, 1'b0);
    stop_test();
  end
  // the run needs about 450 cycles; this allows twenty times that
  initial
  begin
    #450000;
    num_errors++;
    stop_test();
  end
endmodule : test_sadbc_top
bind sadbc_top sadbc_sva sadbc_sva_i (.sys_clk(sys_clk), .srst(srst), .cpu_addr(cpu_addr),
  .cpu_cycle(cpu_cycle), .cpu_write(cpu_write), .flash_select_n(flash_select_n),
  .sram_select(sram_select), .int_io_select(int_io_select), .ext_io_select(ext_io_select),
  .program_patch_service(program_patch_service), .break_addr(break_addr));
